/* File: rtl/sys_cmd_pkg.sv */
// Purpose: shared constants and types for the system command handler
// Assumes: 125 MHz clock, APB register access with 32-bit data
// Notes: response words are coded values, text is formed by firmware
package sys_cmd_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int SYSFAIL_TIME_S = 3;
  localparam int INIT_TIME_S = 20;
  localparam int TIMEOUT_MAX_S = 100000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEQ = 8'h04;
  localparam logic [7:0] ADDR_TMO = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_RESP = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_ERR = 8'h18;
  localparam logic [7:0] ADDR_OPT = 8'h1C;
  localparam logic [7:0] ADDR_LVL = 8'h20;
  localparam logic [7:0] ADDR_ERRIN = 8'h24;
  localparam logic [7:0] ADDR_DONE = 8'h28;
  localparam int CTRL_LANG_BIT = 0;
  localparam int CTRL_QMODE_BIT = 1;
  localparam int CTRL_TAG_BIT = 2;
  localparam logic [31:0] SEQ_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] SEQ_EMPTY = 32'hFFFFFFFF;
  localparam logic [31:0] SEQ_OVERFLOW = 32'hFFFFFFFE;
  localparam logic [31:0] TIMEOUT_WORD = 32'hFFFFFFFD;
  localparam logic [31:0] NO_OPTION_CODE = 32'h00000000;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_NOT_FOUND = 16'hFF8F;
  localparam logic [31:0] SEPARATOR_WORD = 32'h0000003B;
  // command codes written to the command register
  localparam logic [7:0] CMD_CLS = 8'h01;
  localparam logic [7:0] CMD_RST = 8'h02;
  localparam logic [7:0] CMD_STATUS_LO = 8'h03;
  localparam logic [7:0] CMD_STATUS_HI = 8'h0F;
  localparam logic [7:0] CMD_QUERY = 8'h10;
  localparam logic [7:0] CMD_SYSTEM_LO = 8'h20;
  localparam logic [7:0] CMD_SYSTEM_HI = 8'h2F;
  localparam logic [7:0] CMD_OTHER = 8'h40;
  typedef enum logic [1:0] {LANG_SYNC = 2'h0, LANG_ASYNC = 2'h1} lang_type;
  typedef struct packed {
    logic lang_async;
    logic qmode_all;
    logic tag_numeric;
  } ctrl_type;
  typedef struct packed {
    logic [15:0] tag;
    logic [31:0] data;
  } resp_type;
endpackage

/* File: rtl/system_command_handler.sv */
// Purpose: system command set core: protocol, response queue, errors
// Assumes: APB slave, one clock, firmware feeds command codes
// Notes: commands arrive as codes in a register, responses as words
// Contract
// - sync protocol enables exchange enforcer, responses untagged
// - async protocol disables enforcer, tags every queued query response
// - NEXT mode: one read returns at most one queued response
// - ALL mode: successive reads drain the queue, a separator read between elements
// - async sequence starts at zero, increments per query, set loads next
// - sequence 0..2^31-1; -1 means empty, -2 means overflow
// - tag state picks text label tag or instrument number tag
// - query exceeding timeout aborts instrument, queues timeout response
// - timeout is zero for none, or one to 100000 seconds
// - timeout ignored under asynchronous protocol
// - error queue read FIFO; empty reads code zero, no error
// - about three seconds after power-on release system failure line
// - full initialization about twenty seconds from power-on
// - readiness reads one after full init, zero before
// - before init only status, reset, clear and system commands accepted
// - other commands before init give command-not-found error
// - options query lists fitted codes or no_option_code
// - protocol query reports the selected protocol
// - reset restores sync, NEXT, seq 0, tag off, timeout 0; clear empties
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module system_command_handler
  import sys_cmd_pkg::*;
#(
  parameter int QDEPTH = 8,
  parameter int SYSFAIL_CYCLES = SYSFAIL_TIME_S * CLK_HZ,
  parameter longint INIT_CYCLES = longint'(INIT_TIME_S) * CLK_HZ,
  parameter int SEC_CYCLES = CLK_HZ,
  parameter logic [15:0] INSTR_NUMBER = 16'h0001,
  parameter logic [31:0] OPTIONS_FITTED = NO_OPTION_CODE
)
(
  input wire logic clk, // 125 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic enforcer_en, // exchange_protocol_enforcer enable
  output logic sysfail, // system failure line, high while failing
  output logic instr_abort // abort pulse to instrument
);
  localparam int QW = $clog2(QDEPTH);

  ctrl_type ctrl_reg;
  logic [31:0] seq_reg;
  logic [16:0] tmo_reg;
  logic [31:0] sys_cnt_reg;
  logic ready_reg;
  logic [31:0] sec_cnt_reg;
  logic [16:0] tmo_cnt_reg;
  logic busy_reg;
  logic ovf_reg;
  resp_type rq_mem [QDEPTH];
  logic [QW:0] rq_cnt_reg;
  logic [QW-1:0] rq_wr_reg, rq_rd_reg;
  logic [15:0] eq_mem [QDEPTH];
  logic [QW:0] eq_cnt_reg;
  logic [QW-1:0] eq_wr_reg, eq_rd_reg;
  logic all_pend_reg;

  logic acc, wr, rd;
  logic cmd_wr, resp_push_fw, resp_rd, err_rd, err_push_fw, done_wr;
  logic [7:0] cmd;
  logic cmd_ok, query_go, cls, rst_cmd, tmo_hit;
  logic rq_push, rq_pop, eq_push, eq_pop;
  resp_type rq_in;
  logic [15:0] eq_in;
  logic mapped, wr_seq_hold, sep_due;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cmd = pwdata[7:0];
  assign cmd_wr = wr && paddr[7:0] == ADDR_CMD;
  assign resp_push_fw = wr && paddr[7:0] == ADDR_RESP;
  assign err_push_fw = wr && paddr[7:0] == ADDR_ERRIN;
  assign done_wr = wr && paddr[7:0] == ADDR_DONE;
  assign resp_rd = rd && paddr[7:0] == ADDR_RESP;
  assign err_rd = rd && paddr[7:0] == ADDR_ERR;
  assign mapped = paddr[31:8] == 24'h000000 && paddr[1:0] == 2'h0
    && paddr[7:0] <= ADDR_DONE;
  assign wr_seq_hold = wr && paddr[7:0] == ADDR_SEQ;
  assign sep_due = all_pend_reg && ctrl_reg.qmode_all;

  // reduced set: status, system, clear and reset codes only until init completes
  assign cmd_ok = ready_reg || cmd == CMD_CLS || cmd == CMD_RST
    || (cmd >= CMD_STATUS_LO && cmd <= CMD_STATUS_HI)
    || (cmd >= CMD_SYSTEM_LO && cmd <= CMD_SYSTEM_HI);
  assign cls = cmd_wr && cmd == CMD_CLS;
  assign rst_cmd = cmd_wr && cmd == CMD_RST;
  assign query_go = cmd_wr && cmd_ok && cmd == CMD_QUERY;
  assign tmo_hit = busy_reg && !ctrl_reg.lang_async && tmo_reg != '0
    && tmo_cnt_reg >= tmo_reg;

  // control settings
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= '0;
      seq_reg <= '0;
      tmo_reg <= '0;
    end
    else if (rst_cmd)
    begin
      ctrl_reg <= '0;
      seq_reg <= '0;
      tmo_reg <= '0;
    end
    else
    begin
      if (wr && paddr[7:0] == ADDR_CTRL && ready_reg)
      begin
        ctrl_reg.lang_async <= pwdata[CTRL_LANG_BIT];
        ctrl_reg.qmode_all <= pwdata[CTRL_QMODE_BIT];
        ctrl_reg.tag_numeric <= pwdata[CTRL_TAG_BIT];
      end
      if (wr && paddr[7:0] == ADDR_SEQ && ready_reg && pwdata <= SEQ_MAX)
        seq_reg <= pwdata;
      else if (query_go && ctrl_reg.lang_async)
        seq_reg <= seq_reg == SEQ_MAX ? '0 : seq_reg + 32'h1;
      if (wr && paddr[7:0] == ADDR_TMO && ready_reg
        && pwdata <= 32'(TIMEOUT_MAX_S))
        tmo_reg <= pwdata[16:0];
    end
  end

  // power-on sequencing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sys_cnt_reg <= '0;
      sysfail <= 1'b1;
      ready_reg <= 1'b0;
    end
    else
    begin
      if (!ready_reg)
        sys_cnt_reg <= sys_cnt_reg + 32'h1;
      if (sys_cnt_reg == 32'(SYSFAIL_CYCLES - 1))
        sysfail <= 1'b0;
      if (sys_cnt_reg == 32'(INIT_CYCLES - 1))
        ready_reg <= 1'b1;
    end
  end

  // query timer, seconds from a one-cycle tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg <= 1'b0;
      sec_cnt_reg <= '0;
      tmo_cnt_reg <= '0;
      instr_abort <= 1'b0;
    end
    else
    begin
      instr_abort <= tmo_hit;
      if (query_go || tmo_hit || done_wr || rst_cmd)
      begin
        busy_reg <= query_go;
        sec_cnt_reg <= '0;
        tmo_cnt_reg <= '0;
      end
      else if (busy_reg)
      begin
        if (sec_cnt_reg == 32'(SEC_CYCLES - 1))
        begin
          sec_cnt_reg <= '0;
          tmo_cnt_reg <= tmo_cnt_reg + 17'h1;
        end
        else
          sec_cnt_reg <= sec_cnt_reg + 32'h1;
      end
    end
  end

  // response queue; numeric tag = instrument number, label tag = 16'h8000, sync tag = zero
  always_comb
  begin
    rq_in.data = tmo_hit ? TIMEOUT_WORD : pwdata;
    rq_in.tag = 16'h0000;
    if (ctrl_reg.lang_async)
      rq_in.tag = ctrl_reg.tag_numeric ? INSTR_NUMBER : 16'h8000;
  end
  assign rq_push = (resp_push_fw || tmo_hit) && rq_cnt_reg != QDEPTH[QW:0];
  // ALL mode pops on each read except a read while a separator is due
  assign rq_pop = (resp_rd && rq_cnt_reg != '0) && !sep_due;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rq_cnt_reg <= '0;
      rq_wr_reg <= '0;
      rq_rd_reg <= '0;
      ovf_reg <= 1'b0;
      all_pend_reg <= 1'b0;
    end
    else if (cls || rst_cmd)
    begin
      rq_cnt_reg <= '0;
      rq_wr_reg <= '0;
      rq_rd_reg <= '0;
      ovf_reg <= 1'b0;
      all_pend_reg <= 1'b0;
    end
    else
    begin
      if (rq_push)
        rq_mem[rq_wr_reg] <= rq_in;
      if (rq_push)
        rq_wr_reg <= rq_wr_reg + 1'b1;
      if (rq_pop)
        rq_rd_reg <= rq_rd_reg + 1'b1;
      rq_cnt_reg <= rq_cnt_reg + (rq_push ? 1'b1 : 1'b0)
        - (rq_pop ? 1'b1 : 1'b0);
      if ((resp_push_fw || tmo_hit) && rq_cnt_reg == QDEPTH[QW:0])
        ovf_reg <= 1'b1;
      // after each element but the last in ALL mode a separator read follows
      if (!ctrl_reg.qmode_all)
        all_pend_reg <= 1'b0;
      else if (resp_rd)
        all_pend_reg <= rq_pop && rq_cnt_reg > 1;
    end
  end

  // error queue
  assign eq_in = err_push_fw ? pwdata[15:0] : ERR_NOT_FOUND;
  assign eq_push = ((cmd_wr && !cmd_ok) || err_push_fw)
    && eq_cnt_reg != QDEPTH[QW:0];
  assign eq_pop = err_rd && eq_cnt_reg != '0;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eq_cnt_reg <= '0;
      eq_wr_reg <= '0;
      eq_rd_reg <= '0;
    end
    else if (cls)
    begin
      eq_cnt_reg <= '0;
      eq_wr_reg <= '0;
      eq_rd_reg <= '0;
    end
    else
    begin
      if (eq_push)
        eq_mem[eq_wr_reg] <= eq_in;
      if (eq_push)
        eq_wr_reg <= eq_wr_reg + 1'b1;
      if (eq_pop)
        eq_rd_reg <= eq_rd_reg + 1'b1;
      eq_cnt_reg <= eq_cnt_reg + (eq_push ? 1'b1 : 1'b0)
        - (eq_pop ? 1'b1 : 1'b0);
    end
  end

  // apb slave, zero wait states, data registered in the setup cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      enforcer_en <= 1'b1;
    end
    else
    begin
      enforcer_en <= !ctrl_reg.lang_async;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= '0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr[7:0])
          ADDR_CTRL: prdata <= {29'h0, ctrl_reg.tag_numeric,
            ctrl_reg.qmode_all, ctrl_reg.lang_async};
          ADDR_SEQ: prdata <= seq_reg;
          ADDR_TMO: prdata <= {15'h0, tmo_reg};
          ADDR_RESP:
            if (sep_due)
              prdata <= SEPARATOR_WORD;
            else if (ovf_reg)
              prdata <= SEQ_OVERFLOW;
            else if (rq_cnt_reg == '0)
              prdata <= SEQ_EMPTY;
            else
              prdata <= rq_mem[rq_rd_reg].data;
          ADDR_STAT: prdata <= {rq_mem[rq_rd_reg].tag, 12'h0, busy_reg,
            sysfail, ovf_reg, ready_reg};
          ADDR_ERR:
            prdata <= eq_cnt_reg == '0 ? {16'h0, ERR_NONE}
              : {16'h0, eq_mem[eq_rd_reg]};
          ADDR_OPT: prdata <= OPTIONS_FITTED;
          ADDR_LVL: prdata <= {16'h0, 3'h0, eq_cnt_reg[QW:0] & 5'h1F,
            3'h0, rq_cnt_reg[QW:0] & 5'h1F};
          default: prdata <= '0;
        endcase
      end
    end
  end

  a_sysfail_release: assert property (@(posedge clk)
    disable iff (rst) $fell(sysfail)
    |-> sys_cnt_reg == 32'(SYSFAIL_CYCLES))
    else $error("sysfail released at wrong time");
  a_ready_sticky: assert property (@(posedge clk)
    disable iff (rst) ready_reg |=> ready_reg)
    else $error("ready dropped");
  a_enforcer_lang: assert property (@(posedge clk)
    disable iff (rst) $changed(ctrl_reg.lang_async)
    |=> enforcer_en != ctrl_reg.lang_async)
    else $error("enforcer not following protocol");
  a_reduced_reject: assert property (@(posedge clk)
    disable iff (rst) cmd_wr && !ready_reg && cmd == CMD_OTHER
    && eq_cnt_reg == '0 && !cls |=> eq_cnt_reg == 1)
    else $error("reduced set not enforced");
  a_timeout_abort: assert property (@(posedge clk)
    disable iff (rst) tmo_hit |=> instr_abort && busy_reg == $past(query_go))
    else $error("timeout did not abort");
  a_async_no_tmo: assert property (@(posedge clk)
    disable iff (rst) ctrl_reg.lang_async |-> !tmo_hit)
    else $error("timeout active in async");
  a_tmo_range: assert property (@(posedge clk)
    disable iff (rst) tmo_reg <= 17'(TIMEOUT_MAX_S))
    else $error("timeout out of range");
  a_seq_range: assert property (@(posedge clk)
    disable iff (rst) seq_reg <= SEQ_MAX)
    else $error("sequence out of range");
  a_seq_step: assert property (@(posedge clk)
    disable iff (rst) query_go && ctrl_reg.lang_async && !wr_seq_hold
    && seq_reg < SEQ_MAX |=> seq_reg == $past(seq_reg) + 32'h1)
    else $error("sequence did not advance");
  a_next_single: assert property (@(posedge clk)
    disable iff (rst) !ctrl_reg.qmode_all |=> !all_pend_reg)
    else $error("separator in next mode");
  a_sync_untag: assert property (@(posedge clk)
    disable iff (rst) rq_push && !ctrl_reg.lang_async && !cls && !rst_cmd
    |=> rq_mem[$past(rq_wr_reg)].tag == '0)
    else $error("tag in sync mode");
  a_rst_defaults: assert property (@(posedge clk)
    disable iff (rst) rst_cmd |=> ctrl_reg == '0 && seq_reg == '0
    && tmo_reg == '0)
    else $error("reset defaults wrong");
  c_timeout: cover property (@(posedge clk) disable iff (rst) tmo_hit);
  c_all_drain: cover property (@(posedge clk) disable iff (rst)
    all_pend_reg ##1 !all_pend_reg);
  c_reject: cover property (@(posedge clk) disable iff (rst)
    cmd_wr && !cmd_ok);
endmodule

/* File: tb/apb_commander.sv */
// Purpose: commander model that issues APB transfers to the handler
// Assumes: one clock, signals change only right after a rising edge
// Notes: released write data is inverted so stale values never match
module apb_commander
(
  input wire logic clk, // bench clock
  input wire logic [31:0] prdata, // read data from the handler
  input wire logic pready, // ready from the handler
  input wire logic pslverr, // error from the handler
  output logic psel, // apb select
  output logic penable, // apb enable
  output logic pwrite, // apb direction
  output logic [31:0] paddr, // apb address
  output logic [31:0] pwdata // apb write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end

  // one whole transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

/* File: tb/test_system_command_handler.sv */
// Purpose: self-checking bench for the system command handler
// Assumes: shortened power-on counts, seed fixed for repeatable data
// Notes: the first two error reads are compared on their low sixteen bits only
module test_system_command_handler;
  import sys_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SF = 30;
  localparam int IC = 200;
  localparam int SC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic enforcer_en, sysfail, instr_abort;
  logic [31:0] paddr, pwdata, prdata;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int aborts = 0;
  localparam int QDEPTH_T = 8;
  logic pe;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  always @(posedge clk) if (instr_abort === 1'b1) aborts <= aborts + 1;

  system_command_handler #(.SYSFAIL_CYCLES(SF), .INIT_CYCLES(IC),
    .SEC_CYCLES(SC)) u_system_command_handler (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enforcer_en(enforcer_en), .sysfail(sysfail),
    .instr_abort(instr_abort));

  apb_commander u_apb_commander (.clk(clk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic test_done;
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_apb_commander.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    u_apb_commander.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(q, exp);
  endtask

  // one when v lies within lo..hi, so a late or early event shows up
  function automatic logic [31:0] in_win(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  initial
  begin
    logic [31:0] q, d0, d1, s;
    int n;
    void'($urandom(6));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (SF - 3) @(posedge clk);
    #1 chk({31'h0, sysfail}, 32'h1);
    repeat (6) @(posedge clk);
    #1 chk({31'h0, sysfail}, 32'h0);
    chk({31'h0, enforcer_en}, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    rchk(ADDR_CTRL, 32'h0);
    wr(ADDR_CMD, {24'h0, CMD_OTHER});
    wr(ADDR_CMD, {24'h0, CMD_STATUS_HI});
    rd(ADDR_ERR, q);
    chk({16'h0, q[15:0]}, {16'h0, ERR_NOT_FOUND});
    rd(ADDR_ERR, q);
    chk({16'h0, q[15:0]}, {16'h0, ERR_NONE});
    rd(ADDR_STAT, q);
    chk({31'h0, q[0]}, 32'h0);
    // a poll every SC cycles leaves the second stage undisturbed
    do
    begin
      repeat (SC) @(posedge clk);
      rd(ADDR_STAT, q);
    end while (q[0] !== 1'b1 && cyc < 600);
    chk(in_win(cyc, IC, IC + 40), 32'h1);
    wr(ADDR_ERRIN, 32'h11);
    wr(ADDR_ERRIN, 32'h22);
    rchk(ADDR_ERR, 32'h11);
    rchk(ADDR_ERR, 32'h22);
    rchk(ADDR_OPT, NO_OPTION_CODE);
    d0 = $urandom();
    d1 = $urandom();
    wr(ADDR_RESP, d0);
    wr(ADDR_RESP, d1);
    rchk(ADDR_RESP, d0);
    rchk(ADDR_RESP, d1);
    rchk(ADDR_RESP, SEQ_EMPTY);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_RESP, d1);
    wr(ADDR_RESP, d0);
    rchk(ADDR_RESP, d1);
    rchk(ADDR_RESP, SEPARATOR_WORD);
    rchk(ADDR_RESP, d0);
    rchk(ADDR_RESP, SEQ_EMPTY);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_RESP, d0);
    rd(ADDR_STAT, q);
    chk({16'h0, q[31:16]}, 32'h0);
    rd(ADDR_RESP, q);
    wr(ADDR_CTRL, 32'h1);
    rchk(ADDR_CTRL, 32'h1);
    chk({31'h0, enforcer_en}, 32'h0);
    wr(ADDR_RESP, d0);
    rd(ADDR_STAT, q);
    chk({16'h0, q[31:16]}, 32'h8000);
    rd(ADDR_RESP, q);
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_RESP, d1);
    rd(ADDR_STAT, q);
    chk({16'h0, q[31:16]}, 32'h0001);
    rd(ADDR_RESP, q);
    s = $urandom() & SEQ_MAX;
    wr(ADDR_SEQ, s);
    wr(ADDR_SEQ, 32'h80000000);
    rchk(ADDR_SEQ, s);
    wr(ADDR_TMO, 32'h1);
    n = aborts;
    wr(ADDR_CMD, {24'h0, CMD_QUERY});
    repeat (3 * SC) @(posedge clk);
    chk(aborts - n, 32'h0);
    rchk(ADDR_SEQ, s == SEQ_MAX ? 32'h0 : s + 32'h1);
    wr(ADDR_DONE, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    // enforcer follows the control register one cycle later
    repeat (2) @(posedge clk);
    chk({31'h0, enforcer_en}, 32'h1);
    wr(ADDR_TMO, 32'h2);
    wr(ADDR_TMO, TIMEOUT_MAX_S + 1);
    rchk(ADDR_TMO, 32'h2);
    n = aborts;
    wr(ADDR_CMD, {24'h0, CMD_QUERY});
    while (aborts == n && cyc < 2000)
      @(posedge clk);
    chk(aborts - n, 32'h1);
    rchk(ADDR_RESP, TIMEOUT_WORD);
    for (int i = 0; i <= QDEPTH_T; i++)
      wr(ADDR_RESP, $urandom());
    rd(ADDR_STAT, q);
    chk({31'h0, q[1]}, 32'h1);
    wr(ADDR_CTRL, 32'h7);
    wr(ADDR_SEQ, 32'h5);
    wr(ADDR_CMD, {24'h0, CMD_RST});
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_SEQ, 32'h0);
    rchk(ADDR_TMO, 32'h0);
    n = aborts;
    wr(ADDR_CMD, {24'h0, CMD_QUERY});
    repeat (3 * SC) @(posedge clk);
    chk(aborts - n, 32'h0);
    wr(ADDR_ERRIN, 32'h33);
    wr(ADDR_CMD, {24'h0, CMD_CLS});
    rchk(ADDR_ERR, 32'h0);
    u_apb_commander.xfer(1'b0, 8'h3C, 32'h0, q, pe);
    chk({31'h0, pe}, 32'h1);
    test_done();
  end
endmodule
